//--- include/dma_channel_consts.svh
// Offsets, field positions and reset values of the register-file DMA channel.
`ifndef DMA_CHANNEL_CONSTS_SVH
`define DMA_CHANNEL_CONSTS_SVH

// Register indices; the bus byte address is four times the index.
`define DMA_IDX_CONTROL      12'hFB0
`define DMA_IDX_PERIPH       12'hFB1
`define DMA_IDX_HIGH_NIBBLES 12'hFB2
`define DMA_IDX_START_LOW    12'hFB3
`define DMA_IDX_END_LOW      12'hFB4
`define DMA_IDX_IRQ_STATUS   12'hFB5
`define DMA_IDX_IRQ_MASK     12'hFB6

// Control register fields.
`define DMA_CTL_ENABLE       7
`define DMA_CTL_LOOP         6
`define DMA_CTL_DIR          5
`define DMA_CTL_IRQ_EN       4
`define DMA_CTL_WORD         3
`define DMA_CTL_TRIG_HI      2
`define DMA_CTL_TRIG_LO      0

// Trigger source codes.
`define DMA_TRIG_TIMER3      3'h3
`define DMA_TRIG_UART0       3'h4
`define DMA_TRIG_UART1       3'h5
`define DMA_TRIG_I2C         3'h6
`define DMA_TRIG_RESERVED    3'h7

// Peripheral control registers live on this register-file page.
`define DMA_PERIPH_PAGE      4'hF

// Interrupt status bit for end-address reached.
`define DMA_IRQ_END_BIT      0

// Reset values and bus answers.
`define DMA_REG_RESET        8'h00
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

//--- include/dma_channel_pkg.sv
// Types shared by the register-file DMA channel.
package dma_channel_pkg;

  // Transfer sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_LATCH,
    ST_WRITE
  } dma_state_t;

endpackage : dma_channel_pkg

//--- hw/register_file_dma_channel.sv
// Single DMA channel between the register file and peripheral registers, AXI4-Lite slave.
`timescale 1ns/10ps
`include "dma_channel_consts.svh"
// Function
// - 3-bit trigger selects timer, UART or I2C source.
// - Word bit: one or two bytes per request.
// - Interrupt-enable, with mask bit 0 set, raises interrupt after end-address transfer.
// - Direction bit: file-to-peripheral or peripheral-to-file.
// - Loop reloads start, else channel disables at end.
// - Requests serviced only while enable bit is set.
// - 12-bit start/end addresses; shared high nibble register.
// - Start low register reads back current address.
// - Peripheral address is byte on page F.

module register_file_dma_channel
  import dma_channel_pkg::*;
(
  input  wire logic        sys_clk,        // System clock, 50 MHz.
  input  wire logic        rst_b,          // Synchronous reset, active low.
  input  wire logic [15:0] s_axi_awaddr,   // Write address.
  input  wire logic        s_axi_awvalid,  // Write address valid.
  output logic             s_axi_awready,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes.
  input  wire logic        s_axi_wvalid,   // Write data valid.
  output logic             s_axi_wready,   // Write data ready.
  output logic [1:0]       s_axi_bresp,    // Write response.
  output logic             s_axi_bvalid,   // Write response valid.
  input  wire logic        s_axi_bready,   // Write response ready.
  input  wire logic [15:0] s_axi_araddr,   // Read address.
  input  wire logic        s_axi_arvalid,  // Read address valid.
  output logic             s_axi_arready,  // Read address ready.
  output logic [31:0]      s_axi_rdata,    // Read data.
  output logic [1:0]       s_axi_rresp,    // Read response.
  output logic             s_axi_rvalid,   // Read data valid.
  input  wire logic        s_axi_rready,   // Read data ready.
  input  wire logic [3:0]  timerReq,       // Timer 0..3 request levels.
  input  wire logic        uart0RxValid,   // First UART receiver holds data.
  input  wire logic        uart1RxValid,   // Second UART receiver holds data.
  input  wire logic        i2cRxValid,     // I2C receiver holds data.
  output logic [11:0]      memAddr,        // Register-file space address.
  output logic             memRe,          // Read strobe, data next cycle.
  output logic             memWe,          // Write strobe.
  output logic [7:0]       memWrData,      // Write data.
  input  wire logic [7:0]  memRdData,      // Read data, valid cycle after memRe.
  output logic             irq             // Level interrupt.
);

  // ************************************************************
  // Registers and state
  // ************************************************************
  logic [7:0]  dmaControl;        // Control register.
  logic [7:0]  periphAddr;        // Peripheral low address byte.
  logic [11:0] startAddr;         // Loop reload address.
  logic [11:0] endAddr;           // Last address of the range.
  logic [11:0] curAddr;           // Register-file location in work.
  logic [7:0]  irqStatus;         // Sticky event bits.
  logic [7:0]  irqMask;           // Interrupt mask bits.
  dma_state_t  state;             // Sequencer state.
  logic        byteIdx;           // Byte within a word request.
  logic        reqPrev;           // Selected request last cycle.
  logic        reqSel;            // Selected request level.
  logic        reqEdge;           // Selected request rising edge.
  logic        endEvent;          // One-cycle pulse: end byte moved.
  logic [7:0]  periphLow;         // Peripheral byte for this step.
  // Write channel capture.
  logic        awHeld;            // Write address captured.
  logic        wHeld;             // Write data captured.
  logic [15:0] awAddr;            // Captured write address.
  logic [31:0] wData;             // Captured write data.
  logic [3:0]  wStrb;             // Captured strobes.
  logic        doWrite;           // Both halves present, commit now.
  logic        wrHit;             // Write address maps to a register.
  logic [11:0] wrIdx;             // Write register index.
  // Decode a byte address into a register index; flags mapped addresses.
  function automatic logic [12:0] regSel(input logic [15:0] addr);
    logic [11:0] idx;
    logic        hit;
    idx = addr[13:2];
    hit = (addr[15:14] == 2'b00) && (addr[1:0] == 2'b00) &&
          (idx >= `DMA_IDX_CONTROL) && (idx <= `DMA_IDX_IRQ_MASK);
    return {hit, idx};
  endfunction : regSel
  // Next register-file address, wrapping within 12 bits.
  function automatic logic [11:0] incAddr(input logic [11:0] addr);
    return addr + 12'h001;
  endfunction : incAddr
  assign {wrHit, wrIdx} = regSel(awAddr);
  assign doWrite        = awHeld && wHeld && !s_axi_bvalid;

  // ************************************************************
  // Request source selection
  // ************************************************************
  // Pick the trigger source; the reserved code never requests.
  always_comb begin
    case (dmaControl[`DMA_CTL_TRIG_HI:`DMA_CTL_TRIG_LO])
      `DMA_TRIG_UART0: reqSel = uart0RxValid;
      `DMA_TRIG_UART1: reqSel = uart1RxValid;
      `DMA_TRIG_I2C:   reqSel = i2cRxValid;
      `DMA_TRIG_RESERVED: reqSel = 1'b0;
      default:         reqSel = timerReq[dmaControl[1:0]];
    endcase
  end
  // Edges, not levels, start a request so a receiver that keeps its valid
  // high until drained is not serviced twice for one byte.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reqPrev <= 1'b0;
    end else begin
      reqPrev <= reqSel;
    end
  end
  assign reqEdge   = reqSel && !reqPrev;
  assign periphLow = periphAddr + {7'h00, byteIdx};

  // ************************************************************
  // Transfer sequencer and memory port
  // ************************************************************
  // One byte takes read, latch and write cycles; a word repeats it once.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      byteIdx   <= 1'b0;
      memAddr   <= 12'h000;
      memRe     <= 1'b0;
      memWe     <= 1'b0;
      memWrData <= 8'h00;
    end else begin
      memRe <= 1'b0;
      memWe <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Disabled channel ignores every request.
          if (dmaControl[`DMA_CTL_ENABLE] && reqEdge) begin
            byteIdx <= 1'b0;
            state   <= ST_READ;
            memRe   <= 1'b1;
            // Source side depends on the direction bit.
            memAddr <= dmaControl[`DMA_CTL_DIR] ? {`DMA_PERIPH_PAGE, periphAddr}
                                                 : curAddr;
          end
        end
        ST_READ: state <= ST_LATCH;  // Memory answers during this cycle.
        ST_LATCH: begin
          // Read data is valid now; present it to the destination.
          memWe     <= 1'b1;
          memWrData <= memRdData;
          memAddr   <= dmaControl[`DMA_CTL_DIR] ? curAddr
                                                 : {`DMA_PERIPH_PAGE, periphLow};
          state     <= ST_WRITE;
        end
        ST_WRITE: begin
          // A second byte follows unless the end address stopped the run.
          if (dmaControl[`DMA_CTL_WORD] && !byteIdx && !endEvent) begin
            byteIdx <= 1'b1;
            memRe   <= 1'b1;
            memAddr <= dmaControl[`DMA_CTL_DIR] ? {`DMA_PERIPH_PAGE, periphAddr + 8'h01}
                                                 : incAddr(curAddr);
            state   <= ST_READ;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;  // Recover from any stray encoding.
      endcase
    end
  end
  // The byte just written was at the end address.
  assign endEvent = (state == ST_WRITE) && (curAddr == endAddr);

  // ************************************************************
  // Software registers and current address
  // ************************************************************
  // Software writes and hardware updates share this block; hardware's
  // end-of-range actions are applied last so they win a same-cycle write.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dmaControl <= `DMA_REG_RESET;
      periphAddr <= `DMA_REG_RESET;
      startAddr  <= 12'h000;
      endAddr    <= 12'h000;
      curAddr    <= 12'h000;
      irqMask    <= `DMA_REG_RESET;
    end else begin
      if (doWrite && wrHit && wStrb[0]) begin
        case (wrIdx)
          `DMA_IDX_CONTROL: dmaControl <= wData[7:0];
          `DMA_IDX_PERIPH:  periphAddr <= wData[7:0];
          `DMA_IDX_HIGH_NIBBLES: begin
            startAddr[11:8] <= wData[3:0];
            curAddr[11:8]   <= wData[3:0];
            endAddr[11:8]   <= wData[7:4];
          end
          `DMA_IDX_START_LOW: begin
            startAddr[7:0] <= wData[7:0];
            curAddr[7:0]   <= wData[7:0];
          end
          `DMA_IDX_END_LOW:  endAddr[7:0] <= wData[7:0];
          `DMA_IDX_IRQ_MASK: irqMask      <= wData[7:0];
          default: ;  // Status clears live in their own block.
        endcase
      end
      if (state == ST_WRITE) begin
        if (endEvent) begin
          // Loop reloads the start; otherwise the channel stops itself.
          if (dmaControl[`DMA_CTL_LOOP]) begin
            curAddr <= startAddr;
          end else begin
            curAddr                      <= incAddr(curAddr);
            dmaControl[`DMA_CTL_ENABLE] <= 1'b0;
          end
        end else begin
          curAddr <= incAddr(curAddr);
        end
      end
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // Write-one-to-clear; a new event in the same cycle wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irqStatus <= `DMA_REG_RESET;
    end else begin
      if (doWrite && wrHit && wStrb[0] && (wrIdx == `DMA_IDX_IRQ_STATUS)) begin
        irqStatus <= irqStatus & ~wData[7:0];
      end
      if (endEvent && dmaControl[`DMA_CTL_IRQ_EN]) begin
        irqStatus[`DMA_IRQ_END_BIT] <= 1'b1;
      end
    end
  end
  assign irq = |(irqStatus & irqMask);

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  // Address and data are taken in either order; the answer follows both.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 16'h0000;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic        rdHit;  // Read address maps to a register.
  logic [11:0] rdIdx;  // Read register index.
  logic [7:0]  rdByte; // Selected register value.
  assign {rdHit, rdIdx} = regSel(s_axi_araddr);
  assign s_axi_arready  = !s_axi_rvalid;
  // Register read mux; start low shows the live current address.
  always_comb begin
    case (rdIdx)
      `DMA_IDX_CONTROL:      rdByte = dmaControl;
      `DMA_IDX_PERIPH:       rdByte = periphAddr;
      `DMA_IDX_HIGH_NIBBLES: rdByte = {endAddr[11:8], curAddr[11:8]};
      `DMA_IDX_START_LOW:    rdByte = curAddr[7:0];
      `DMA_IDX_END_LOW:      rdByte = endAddr[7:0];
      `DMA_IDX_IRQ_STATUS:   rdByte = irqStatus;
      `DMA_IDX_IRQ_MASK:     rdByte = irqMask;
      default:               rdByte = 8'h00;
    endcase
  end
  // One read in flight; data held until the master takes it.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdHit ? {24'h000000, rdByte} : 32'h0000_0000;
      s_axi_rresp  <= rdHit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // Every check samples on the system clock and sleeps while reset is held.
  default clocking cbSys @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_reserved_idle;
    (state == ST_IDLE && dmaControl[2:0] == `DMA_TRIG_RESERVED) |=> !memRe;
  endproperty
  a_reserved_idle: assert property (p_reserved_idle)
    else $error("Reserved trigger started a transfer.");
  property p_byte_one_write;
    (state == ST_WRITE && !dmaControl[`DMA_CTL_WORD]) |=> (state == ST_IDLE);
  endproperty
  a_byte_one_write: assert property (p_byte_one_write)
    else $error("Byte mode moved more than one byte.");
  property p_word_second;
    (state == ST_WRITE && dmaControl[`DMA_CTL_WORD] && !byteIdx && !endEvent)
      |=> memRe ##2 memWe;
  endproperty
  a_word_second: assert property (p_word_second)
    else $error("Word mode missed its second byte.");
  property p_irq_end;
    (endEvent && dmaControl[`DMA_CTL_IRQ_EN]) |=> irqStatus[`DMA_IRQ_END_BIT];
  endproperty
  a_irq_end: assert property (p_irq_end)
    else $error("End transfer did not set interrupt status.");
  property p_dir_dest;
    (memWe && dmaControl[`DMA_CTL_DIR]) |-> (memAddr[11:8] == $past(curAddr[11:8]));
  endproperty
  a_dir_dest: assert property (p_dir_dest)
    else $error("Inbound transfer wrote outside the register file address.");
  property p_stop_at_end;
    (endEvent && !dmaControl[`DMA_CTL_LOOP]) |=> !dmaControl[`DMA_CTL_ENABLE];
  endproperty
  a_stop_at_end: assert property (p_stop_at_end)
    else $error("Channel stayed enabled after end without loop.");
  property p_loop_reload;
    (endEvent && dmaControl[`DMA_CTL_LOOP] && !doWrite) |=> (curAddr == $past(startAddr));
  endproperty
  a_loop_reload: assert property (p_loop_reload)
    else $error("Loop did not reload the start address.");
  property p_disabled_ignores;
    (state == ST_IDLE && !dmaControl[`DMA_CTL_ENABLE]) |=> (state == ST_IDLE);
  endproperty
  a_disabled_ignores: assert property (p_disabled_ignores)
    else $error("Disabled channel serviced a request.");
  property p_periph_page;
    (memWe && !dmaControl[`DMA_CTL_DIR]) |-> (memAddr[11:8] == `DMA_PERIPH_PAGE);
  endproperty
  a_periph_page: assert property (p_periph_page)
    else $error("Peripheral write left page F.");
  property p_advance;
    (state == ST_WRITE && !endEvent && !doWrite) |=> (curAddr == $past(curAddr) + 12'h001);
  endproperty
  a_advance: assert property (p_advance)
    else $error("Current address did not advance by one byte.");

endmodule : register_file_dma_channel

//--- bench/reg_space_model.sv
// Behavioural register file and peripheral page that answers the channel's byte strobes.
`timescale 1ns/10ps

module reg_space_model (
  input  wire logic        sys_clk,    // System clock.
  input  wire logic [11:0] memAddr,    // Byte address from the channel.
  input  wire logic        memRe,      // Read strobe.
  input  wire logic        memWe,      // Write strobe.
  input  wire logic [7:0]  memWrData,  // Byte to store.
  output logic      [7:0]  memRdData   // Byte returned the cycle after a read strobe.
);
  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0] mem [0:4095];  // Whole 12-bit space; the bench preloads it.

  initial begin
    memRdData = 8'hA5;
  end

  // Read data is valid for exactly one cycle after the strobe.
  // Outside that cycle the bus toggles, so a sample one cycle late sees the inverted byte.
  always @(posedge sys_clk) begin
    if (memWe === 1'b1) begin
      mem[memAddr] <= memWrData;
    end
    if (memRe === 1'b1) begin
      memRdData <= mem[memAddr];
    end else begin
      memRdData <= ~memRdData;
    end
  end
endmodule : reg_space_model

//--- bench/test_register_file_dma_channel.sv
// Self-checking testbench of the register-file DMA channel.
`timescale 1ns/10ps
`include "dma_channel_consts.svh"

module test_register_file_dma_channel;
  import dma_channel_pkg::*;
  typedef struct {logic [2:0] trig; logic dir; logic word; int cnt;} row_t;

  logic        sys_clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, memRe, memWe, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [6:0]  srcs;       // Timer 0..3, UART 0, UART 1, I2C request levels.
  logic [11:0] memAddr, s;
  logic [7:0]  memWrData, memRdData, p;
  logic [31:0] d;
  int          errCount, comparisons, weCount, w, i, k;
  // Each row: trigger, direction and width in, bytes moved out.
  row_t rows [7] = '{'{0, 0, 0, 1}, '{1, 1, 0, 1}, '{2, 0, 1, 2}, '{3, 1, 1, 2},
                     '{4, 0, 0, 1}, '{5, 1, 1, 2}, '{6, 0, 1, 2}};

  register_file_dma_channel u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timerReq(srcs[3:0]), .uart0RxValid(srcs[4]), .uart1RxValid(srcs[5]),
    .i2cRxValid(srcs[6]), .memAddr(memAddr), .memRe(memRe), .memWe(memWe),
    .memWrData(memWrData), .memRdData(memRdData), .irq(irq));

  reg_space_model u_mem (.sys_clk(sys_clk), .memAddr(memAddr), .memRe(memRe),
    .memWe(memWe), .memWrData(memWrData), .memRdData(memRdData));

  // ************************************************************
  // Helpers
  // ************************************************************
  // Preload pattern; distinct in the low byte so a wrong source shows.
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h3C;
  endfunction : pat

  always @(posedge sys_clk) begin
    if (memWe === 1'b1) begin
      weCount++;
    end
  end

  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrapUp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // A wait that ran out ends the run as a failure.
  task automatic guard(input bit ok);
    if (!ok) begin
      errCount++;
      $display("BAD %0t bus wait ran out", $time);
      wrapUp();
    end
  endtask : guard

  // Address and data offered together; each dropped at the edge that takes it.
  task automatic axiWrite(input logic [11:0] idx, input logic [7:0] val);
    bit awOpen, wOpen, awHit, wHit, done;
    int n;
    @(posedge sys_clk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h000000, val};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    awOpen = 1;
    wOpen = 1;
    done = 0;
    for (n = 0; n < 40 && (awOpen || wOpen); n++) begin
      @(negedge sys_clk);
      awHit = awOpen && (awready === 1'b1);
      wHit = wOpen && (wready === 1'b1);
      @(posedge sys_clk);
      if (awHit) begin
        awvalid <= 1'b0;
        awOpen = 0;
      end
      if (wHit) begin
        wvalid <= 1'b0;
        wOpen = 0;
      end
    end
    for (n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      done = (bvalid === 1'b1);
      resp = bresp;
    end
    guard(done && !awOpen && !wOpen);
    @(posedge sys_clk);
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [11:0] idx);
    bit arOpen, done;
    int n;
    @(posedge sys_clk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    arOpen = 1;
    done = 0;
    for (n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      done = (rvalid === 1'b1);
      d = rdata;
      resp = rresp;
      if (arOpen && arready === 1'b1) begin
        @(posedge sys_clk);
        arvalid <= 1'b0;
        arOpen = 0;
      end
    end
    guard(done);
    @(posedge sys_clk);
    rready <= 1'b0;
  endtask : axiRead

  // Start and end go in before control so the current address is loaded first.
  task automatic cfg(input logic [11:0] st, input logic [11:0] en, input logic [7:0] pa,
                     input logic [7:0] ctl);
    axiWrite(`DMA_IDX_HIGH_NIBBLES, {en[11:8], st[11:8]});
    axiWrite(`DMA_IDX_START_LOW, st[7:0]);
    axiWrite(`DMA_IDX_END_LOW, en[7:0]);
    axiWrite(`DMA_IDX_PERIPH, pa);
    axiWrite(`DMA_IDX_CONTROL, ctl);
  endtask : cfg

  // A rising edge on the chosen source; code 7 raises every source at once.
  task automatic fire(input logic [2:0] code);
    @(posedge sys_clk);
    srcs <= (code == 3'h7) ? 7'h7F : (7'h01 << code);
    repeat (12) @(posedge sys_clk);
    srcs <= 7'h00;
    repeat (2) @(posedge sys_clk);
  endtask : fire

  task automatic readCheck(input logic [11:0] idx, input logic [7:0] exp, input string what);
    axiRead(idx);
    check(d, {24'h000000, exp}, what);
  endtask : readCheck

  task automatic irqCheck(input logic exp);
    @(negedge sys_clk);
    check({31'h0, irq}, {31'h0, exp}, "irq");
  endtask : irqCheck

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, srcs} = '0;
    for (i = 0; i < 4096; i++) begin
      u_mem.mem[i] = pat(12'(i));
    end
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    readCheck(`DMA_IDX_CONTROL, 8'h00, "control reset");
    irqCheck(1'b0);
    axiRead(12'hFB7);
    check({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR}, "unmapped read");
    axiWrite(12'hFB7, 8'hFF);
    check({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR}, "unmapped write");
    // Table: trigger codes 0 to 6, both directions, both widths.
    for (i = 0; i < 7; i++) begin
      s = 12'h100 + 12'(i * 16);
      p = 8'h40 + 8'(i * 8);
      cfg(s, s + 12'h00F, p, {1'b1, 1'b0, rows[i].dir, 1'b0, rows[i].word, rows[i].trig});
      w = weCount;
      fire(rows[i].trig);
      check(32'(weCount - w), 32'(rows[i].cnt), "bytes moved");
      for (k = 0; k < rows[i].cnt; k++) begin
        if (rows[i].dir) begin
          check(u_mem.mem[s + 12'(k)], pat({4'hF, p + 8'(k)}), "into file");
        end else begin
          check(u_mem.mem[{4'hF, p + 8'(k)}], pat(s + 12'(k)), "to periph");
        end
      end
      readCheck(`DMA_IDX_START_LOW, 8'(s + 12'(rows[i].cnt)), "current");
    end
    // Mid-run reset: control and the live address fall back to zero.
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    readCheck(`DMA_IDX_CONTROL, 8'h00, "control after reset");
    readCheck(`DMA_IDX_START_LOW, 8'h00, "current after reset");
    // Reserved trigger, then a cleared enable: nothing moves.
    cfg(12'h400, 12'h40F, 8'hC0, 8'h87);
    w = weCount;
    fire(3'h7);
    check(32'(weCount - w), 32'h0, "reserved code");
    axiWrite(`DMA_IDX_CONTROL, 8'h00);
    fire(3'h0);
    check(32'(weCount - w), 32'h0, "disabled");
    // End without loop: interrupt, self-disable, then mask and clear.
    cfg(12'h200, 12'h201, 8'hA0, 8'h90);
    axiWrite(`DMA_IDX_IRQ_MASK, 8'h01);
    fire(3'h0);
    irqCheck(1'b0);
    fire(3'h0);
    irqCheck(1'b1);
    readCheck(`DMA_IDX_CONTROL, 8'h10, "self disable");
    readCheck(`DMA_IDX_START_LOW, 8'h02, "current at end");
    w = weCount;
    fire(3'h0);
    check(32'(weCount - w), 32'h0, "after end");
    axiWrite(`DMA_IDX_IRQ_MASK, 8'h00);
    irqCheck(1'b0);
    axiWrite(`DMA_IDX_IRQ_MASK, 8'h01);
    irqCheck(1'b1);
    axiWrite(`DMA_IDX_IRQ_STATUS, 8'h01);
    check({30'h0, resp}, {30'h0, `AXI_RESP_OKAY}, "clear answer");
    irqCheck(1'b0);
    // Word transfer that ends on the end address with loop set and no interrupt.
    cfg(12'h300, 12'h301, 8'hD0, 8'hCC);
    w = weCount;
    fire(3'h4);
    fire(3'h4);
    check(32'(weCount - w), 32'h4, "loop keeps running");
    readCheck(`DMA_IDX_HIGH_NIBBLES, 8'h33, "reload high");
    readCheck(`DMA_IDX_START_LOW, 8'h00, "reload low");
    readCheck(`DMA_IDX_IRQ_STATUS, 8'h00, "no status");
    irqCheck(1'b0);
    // A word whose first byte sits on the end address stops after that byte.
    cfg(12'h500, 12'h500, 8'hE0, 8'h88);
    w = weCount;
    fire(3'h0);
    check(32'(weCount - w), 32'h1, "word cut at end");
    readCheck(`DMA_IDX_CONTROL, 8'h08, "word end disable");
    wrapUp();
  end
endmodule : test_register_file_dma_channel
